// [core/rtcic_top.v]
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "rtcic_map.vh"
module rtcic_top #(
  parameter TICK_CYC = `RTCIC_TICK_CYC
)(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // interrupt request
  output wire        irq_o,
  // calendar and stopwatch datapath events
  input  wire        day_inc_i,
  input  wire        hour_inc_i,
  input  wire        min_inc_i,
  input  wire        alarm_match_i,
  input  wire        sw_hund_inc_i,
  input  wire        sw_tenth_inc_i,
  input  wire        sw_tenth_ovf_i,
  // calendar datapath control
  output wire        sec_inc_o,
  output wire        adj30_o,
  output wire        calendar_run_o,
  output wire        hour_format_24_o
);

  localparam [2:0] T_IDLE  = 3'b001;
  localparam [2:0] T_WAIT  = 3'b010;
  localparam [2:0] T_APPLY = 3'b100;
  // widen first, then cut to the prescaler width on purpose
  localparam [31:0] TICK_CYC_W = TICK_CYC;
  localparam [17:0] TICK_LAST  = TICK_CYC_W[17:0] - 18'h0_0001;

  reg  [31:0] dat_r;
  reg         ack_r;
  reg         irq_r;
  reg  [12:0] flag_r;
  reg  [12:0] en_r;
  reg  [17:0] pre_r;
  reg  [7:0]  hz_r;
  reg  [4:0]  pend_r;
  reg         alm_pend_r;
  reg         alm_prev_r;
  reg         run_r;
  reg         h24_r;
  reg         hold_r;
  reg         adj_r;
  reg         drst_r;
  reg         cbsy_r;
  reg         missed_r;
  reg         sec_inc_r;
  reg         adj30_r;
  reg  [6:0]  trim_r;
  reg  [2:0]  tst_r;
  reg  [2:0]  tst_nxt;
  reg  [12:0] flag_set;
  reg  [31:0] rd_nxt;

  wire        req     = wb_cyc_i & wb_stb_i;
  // writes land on the edge that sees ack high
  wire        wr      = req & wb_we_i & ack_r;
  wire        wr_ctl  = wr & (wb_adr_i == `RTCIC_CTL_OFF);
  wire        wr_flag = wr & (wb_adr_i == `RTCIC_FLAG_OFF);
  wire        wr_en   = wr & (wb_adr_i == `RTCIC_ENAB_OFF);
  wire        tbsy    = ~tst_r[0];
  wire [6:0]  tadd    = (tst_r[2] && trim_r != 7'h00) ? trim_r : 7'h00;
  wire [17:0] term    = TICK_LAST + {{11{tadd[6]}}, tadd};
  wire        tick    = (pre_r >= term);
  wire [7:0]  hz_nxt  = hz_r + 8'h01;
  wire        e32     = (hz_nxt[2:0] == 3'h0);
  wire        e8      = (hz_nxt[4:0] == 5'h00);
  wire        e4      = (hz_nxt[5:0] == 6'h00);
  wire        e2      = (hz_nxt[6:0] == 7'h00);
  wire        e1      = (hz_nxt == 8'h00);
  wire        alm_rise = alarm_match_i & ~alm_prev_r;
  wire        sec_due = tick & e1 & run_r;
  wire        catchup = ~hold_r & missed_r;
  wire        adj_go  = tick & adj_r;
  wire        trim_wr = wr_ctl & wb_sel_i[1] & ~tbsy;

  // trim sequencer: wait for divider phase, lengthen or shorten one step by the signed trim, finish
  always @*
  begin
    tst_nxt = tst_r;
    case (tst_r)
      T_IDLE:
      begin
        if (trim_wr)
          tst_nxt = T_WAIT;
      end
      T_WAIT:
      begin
        if (tick && hz_nxt == `RTCIC_TRIM_PHASE)
          tst_nxt = T_APPLY;
      end
      T_APPLY:
      begin
        if (tick)
          tst_nxt = T_IDLE;
      end
      default:
        tst_nxt = T_IDLE;
    endcase
  end

  // flag set sources
  always @*
  begin
    flag_set = `RTCIC_FLAG_RST;
    if (tick)
    begin
      flag_set[`RTCIC_F_SEC32] = pend_r[0];
      flag_set[`RTCIC_F_SEC8]  = pend_r[1];
      flag_set[`RTCIC_F_SEC4]  = pend_r[2];
      flag_set[`RTCIC_F_SEC2]  = pend_r[3];
      flag_set[`RTCIC_F_SEC]   = pend_r[4];
    end
    if (catchup || adj_go)
      flag_set[`RTCIC_F_SEC] = 1'b1;
    flag_set[`RTCIC_F_MIN]  = min_inc_i;
    flag_set[`RTCIC_F_HOUR] = hour_inc_i;
    flag_set[`RTCIC_F_DAY]  = day_inc_i;
    flag_set[`RTCIC_F_ALARM] = tick & alm_pend_r;
    flag_set[`RTCIC_F_SW100] = sw_hund_inc_i;
    flag_set[`RTCIC_F_SW10]  = sw_tenth_inc_i;
    flag_set[`RTCIC_F_SW1]   = sw_tenth_ovf_i;
    flag_set[`RTCIC_F_TRIM]  = tst_r[2] & tick;
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `RTCIC_CTL_OFF:
      begin
        rd_nxt[`RTCIC_CTL_TBSY] = tbsy;
        rd_nxt[`RTCIC_CTL_CBSY] = cbsy_r;
        rd_nxt[`RTCIC_CTL_HOLD] = hold_r;
        rd_nxt[`RTCIC_CTL_H24]  = h24_r;
        rd_nxt[`RTCIC_CTL_ADJ]  = adj_r;
        rd_nxt[`RTCIC_CTL_DRST] = drst_r;
        rd_nxt[`RTCIC_CTL_RUN]  = run_r;
      end
      `RTCIC_FLAG_OFF:
        rd_nxt[12:0] = flag_r;
      `RTCIC_ENAB_OFF:
        rd_nxt[12:0] = en_r;
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus handshake: one wait state, ack drops after one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r)
        dat_r <= rd_nxt;
    end
  end

  // flags, enables, interrupt
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_r <= `RTCIC_FLAG_RST;
      en_r   <= `RTCIC_FLAG_RST;
      irq_r  <= 1'b0;
    end
    else
    begin
      if (wr_flag)
        flag_r <= (flag_r & ~{wb_sel_i[1] ? wb_dat_i[12:8] : 5'h00,
                              wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00}) | flag_set;
      else
        flag_r <= flag_r | flag_set;
      if (wr_en && wb_sel_i[0])
        en_r[7:0] <= wb_dat_i[7:0];
      if (wr_en && wb_sel_i[1])
        en_r[12:8] <= wb_dat_i[12:8];
      irq_r <= |(flag_r & en_r);
    end
  end

  // 1/256 s prescaler and 1 Hz divider
  always @(posedge clk_i)
  begin
    if (rst_i || drst_r)
    begin
      pre_r  <= 18'h0_0000;
      hz_r   <= `RTCIC_HZ_RST;
      pend_r <= 5'h00;
    end
    else if (tick)
    begin
      pre_r  <= 18'h0_0000;
      hz_r   <= hz_nxt;
      pend_r <= {e1, e2, e4, e8, e32};
    end
    else
      pre_r <= pre_r + 18'h0_0001;
  end

  // alarm edge held until next step
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alm_prev_r <= 1'b0;
      alm_pend_r <= 1'b0;
    end
    else
    begin
      alm_prev_r <= alarm_match_i;
      alm_pend_r <= (alm_pend_r & ~tick) | alm_rise;
    end
  end

  // trim sequencer state and value
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tst_r  <= T_IDLE;
      trim_r <= `RTCIC_TRIM_RST;
    end
    else
    begin
      tst_r <= tst_nxt;
      if (trim_wr)
        trim_r <= wb_dat_i[`RTCIC_CTL_TRIM_HI:`RTCIC_CTL_TRIM_LO];
    end
  end

  // control bits and calendar steps
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_r     <= 1'b0;
      h24_r     <= 1'b0;
      hold_r    <= 1'b0;
      adj_r     <= 1'b0;
      drst_r    <= 1'b0;
      cbsy_r    <= 1'b0;
      missed_r  <= 1'b0;
      sec_inc_r <= 1'b0;
      adj30_r   <= 1'b0;
    end
    else
    begin
      if (wr_ctl && wb_sel_i[0])
      begin
        run_r <= wb_dat_i[`RTCIC_CTL_RUN];
        h24_r <= wb_dat_i[`RTCIC_CTL_H24];
      end
      drst_r <= wr_ctl & wb_sel_i[0] & wb_dat_i[`RTCIC_CTL_DRST];
      if (tbsy || drst_r)
        hold_r <= 1'b0;
      else if (wr_ctl && wb_sel_i[0])
        hold_r <= wb_dat_i[`RTCIC_CTL_HOLD];
      if (drst_r)
        adj_r <= 1'b0;
      else if (wr_ctl && wb_sel_i[0] && wb_dat_i[`RTCIC_CTL_ADJ])
        adj_r <= 1'b1;
      else if (adj_go)
        adj_r <= 1'b0;
      adj30_r <= adj_go;
      if (hold_r)
        missed_r <= missed_r | sec_due;
      else
        missed_r <= 1'b0;
      sec_inc_r <= (sec_due & ~hold_r) | catchup;
      if ((sec_due && !hold_r) || catchup || adj_go)
        cbsy_r <= 1'b1;
      else if (tick)
        cbsy_r <= 1'b0;
    end
  end

  assign wb_dat_o         = dat_r;
  assign wb_ack_o         = ack_r;
  assign irq_o            = irq_r;
  assign sec_inc_o        = sec_inc_r;
  assign adj30_o          = adj30_r;
  assign calendar_run_o   = run_r;
  assign hour_format_24_o = h24_r;

endmodule

// [common/rtcic_map.vh]
`ifndef RTCIC_MAP_VH
`define RTCIC_MAP_VH
// register offsets (byte addresses)
`define RTCIC_CTL_OFF       8'h00
`define RTCIC_FLAG_OFF      8'h04
`define RTCIC_ENAB_OFF      8'h08
// clock_control fields
`define RTCIC_CTL_RUN       0
`define RTCIC_CTL_DRST      1
`define RTCIC_CTL_ADJ       2
`define RTCIC_CTL_H24       4
`define RTCIC_CTL_HOLD      5
`define RTCIC_CTL_CBSY      6
`define RTCIC_CTL_TRIM_LO   8
`define RTCIC_CTL_TRIM_HI   14
`define RTCIC_CTL_TBSY      15
// irq_flags / irq_enables fields
`define RTCIC_F_SEC32       0
`define RTCIC_F_SEC8        1
`define RTCIC_F_SEC4        2
`define RTCIC_F_SEC2        3
`define RTCIC_F_SEC         4
`define RTCIC_F_MIN         5
`define RTCIC_F_HOUR        6
`define RTCIC_F_DAY         7
`define RTCIC_F_ALARM       8
`define RTCIC_F_SW100       9
`define RTCIC_F_SW10        10
`define RTCIC_F_SW1         11
`define RTCIC_F_TRIM        12
`define RTCIC_NFLAG         13
// reset values
`define RTCIC_FLAG_RST      13'h0000
`define RTCIC_TRIM_RST      7'h00
`define RTCIC_HZ_RST        8'h00
// timing: one divider step is 1/256 s
`define RTCIC_CLK_HZ        25000000
`define RTCIC_STEP_PER_SEC  256
`define RTCIC_TICK_CYC      (`RTCIC_CLK_HZ / `RTCIC_STEP_PER_SEC)
`define RTCIC_TRIM_PHASE    8'h7f
`endif

// [sim/rtcic_top_assertions.sv]
`timescale 1ns/100ps
`include "rtcic_map.vh"
module rtcic_top_assertions #(
  parameter TICK_CYC = 8
)(
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        irq_o,
  input wire        sec_inc_o,
  input wire        adj30_o,
  input wire        calendar_run_o,
  input wire        hour_format_24_o
);
  localparam int ADJ_MAX = 2 * TICK_CYC + 4;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr(a);
    wb_ack_o && wb_we_i && wb_adr_i == a;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_trim_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
    wb_dat_o[14:8] == 7'h00) else $error("trim read nonzero");
  a_adj_within: assert property (s_wr(8'h00) ##0 (wb_sel_i[0] && wb_dat_i[2]) |->
    ##[1:ADJ_MAX] adj30_o) else $error("adjust late");
  a_sec_run: assert property (sec_inc_o |-> calendar_run_o || $past(calendar_run_o))
    else $error("second while stopped");
  a_run_set: assert property (s_wr(8'h00) ##0 (wb_sel_i[0] && wb_dat_i[0]) |->
    ##[1:2] calendar_run_o) else $error("run not set");
  a_h24_clear: assert property (s_wr(8'h00) ##0 (wb_sel_i[0] && !wb_dat_i[4]) |->
    ##[1:2] !hour_format_24_o) else $error("h24 not cleared");
  a_irq_masked: assert property (s_wr(8'h08) ##0 (wb_sel_i == 4'h3 &&
    wb_dat_i[12:0] == 13'h0000) |-> ##[1:3] !irq_o) else $error("irq while masked");
endmodule
bind rtcic_top rtcic_top_assertions #(.TICK_CYC(TICK_CYC)) rtcic_top_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sec_inc_o(sec_inc_o),
  .adj30_o(adj30_o), .calendar_run_o(calendar_run_o), .hour_format_24_o(hour_format_24_o));

// [sim/rtcic_cal_model.sv]
`timescale 1ns/100ps
module rtcic_cal_model #(
  parameter ALARM_SEC = 1
)(
  input  wire clk_i,
  input  wire rst_i,
  input  wire sec_inc_i,
  input  wire adj30_i,
  output reg  min_inc_o,
  output wire alarm_match_o
);
  reg [5:0] sec_r;
  always @(posedge clk_i)
  begin
    min_inc_o <= 1'b0;
    if (rst_i)
      sec_r <= 6'h00;
    else if (adj30_i)
    begin
      min_inc_o <= (sec_r >= 6'h1e);
      sec_r <= 6'h00;
    end
    else if (sec_inc_i)
    begin
      min_inc_o <= (sec_r == 6'h3b);
      sec_r <= (sec_r == 6'h3b) ? 6'h00 : sec_r + 6'h01;
    end
  end
  assign alarm_match_o = (sec_r == ALARM_SEC);
endmodule

// [sim/rtcic_top_tb.sv]
`timescale 1ns/100ps
module rtcic_top_tb;
  localparam TICK = 8;
  localparam SEC = 256 * TICK;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [3:0]  sel = 4'h0;
  reg  [31:0] wd = 32'h0000_0000;
  reg  [4:0]  ev = 5'h00;
  wire [31:0] rd_o;
  wire        ack, irq, sec, adj, run, h24, min_inc, alm;
  integer     miscompares = 0, n_checks = 0, seed = 61653, ncyc = 0, nsec = 0, n0;
  logic [31:0] exp_q[$], msk_q[$], e;
  rtcic_top #(.TICK_CYC(TICK)) rtcic_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .irq_o(irq), .day_inc_i(ev[0]), .hour_inc_i(ev[1]), .min_inc_i(min_inc),
    .alarm_match_i(alm), .sw_hund_inc_i(ev[2]), .sw_tenth_inc_i(ev[3]),
    .sw_tenth_ovf_i(ev[4]), .sec_inc_o(sec), .adj30_o(adj), .calendar_run_o(run),
    .hour_format_24_o(h24));
  rtcic_cal_model rtcic_cal_model_inst (.clk_i(clk_i), .rst_i(rst_i), .sec_inc_i(sec),
    .adj30_i(adj), .min_inc_o(min_inc), .alarm_match_o(alm));
  initial
    forever #20 clk_i = ~clk_i;
  task check(input logic [31:0] s, input logic [31:0] x, input string w);
    n_checks++;
    if (s !== x)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", w, x, s);
    end
  endtask
  task summarize;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    cyc <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x);
    msk_q.push_back(m);
    bus(1'b0, a, $random(seed), 4'h3);
  endtask
  // read results scored in order
  always @(posedge clk_i)
  begin
    ncyc <= ncyc + 1;
    if (sec === 1'b1)
      nsec <= nsec + 1;
    if (ack === 1'b1 && !we)
      check(rd_o & msk_q.pop_front(), exp_q.pop_front(), "read");
    if (ncyc == 60000)
    begin
      miscompares++;
      summarize;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 0, '1);
    rd(8'h04, 0, '1);
    rd(8'h0c, 0, '1);
    $display("reset test done");
    e = $random(seed);
    @(posedge clk_i);
    ev <= e[4:0];
    @(posedge clk_i);
    ev <= 5'h00;
    e = {20'h0_0000, e[4:2], 1'b0, e[0], e[1], 6'h00};
    rd(8'h04, e, 32'h0000_0ec0);
    bus(1'b1, 8'h08, 32'h0000_1fff, 4'h3);
    repeat (3) @(posedge clk_i);
    check(irq, (e != 0), "irq");
    bus(1'b1, 8'h08, 0, 4'h3);
    bus(1'b1, 8'h04, e, 4'h3);
    rd(8'h04, 0, 32'h0000_0ec0);
    $display("flag test done");
    bus(1'b1, 8'h00, 32'h0000_0011, 4'h1);
    repeat (SEC + 4 * TICK) @(posedge clk_i);
    rd(8'h04, 32'h0000_011f, 32'h0000_011f);
    bus(1'b1, 8'h04, 32'h0000_1fff, 4'h3);
    bus(1'b1, 8'h00, 32'h0000_0031, 4'h1);
    n0 = nsec;
    repeat (2 * SEC) @(posedge clk_i);
    check(nsec, n0, "held seconds");
    bus(1'b1, 8'h00, 32'h0000_0011, 4'h1);
    repeat (4) @(posedge clk_i);
    check(nsec, n0 + 1, "catch-up");
    bus(1'b1, 8'h00, 32'h0000_0031, 4'h1);
    bus(1'b1, 8'h00, 32'h0000_0033, 4'h1);
    rd(8'h00, 32'h0000_0011, 32'h0000_0037);
    $display("hold test done");
    bus(1'b1, 8'h00, 32'h0000_0010, 4'h1);
    bus(1'b1, 8'h04, 32'h0000_1fff, 4'h3);
    bus(1'b1, 8'h00, 32'h0000_0014, 4'h1);
    repeat (3 * TICK) @(posedge clk_i);
    rd(8'h04, 32'h0000_0010, 32'h0000_0010);
    rd(8'h00, 32'h0000_0010, 32'h0000_0015);
    $display("adjust test done");
    bus(1'b1, 8'h00, 32'h0000_0510, 4'h3);
    bus(1'b1, 8'h00, 32'h0000_0730, 4'h3);
    rd(8'h00, 32'h0000_8010, 32'h0000_ff30);
    n0 = nsec;
    repeat (SEC + 8 * TICK) @(posedge clk_i);
    check(nsec, n0, "stopped seconds");
    rd(8'h00, 32'h0000_0010, 32'h0000_8030);
    rd(8'h04, 32'h0000_1000, 32'h0000_1000);
    bus(1'b1, 8'h00, 0, 4'h2);
    rd(8'h00, 32'h0000_8000, 32'h0000_8000);
    $display("trim test done");
    repeat (4) @(posedge clk_i);
    summarize;
  end
endmodule
